/* File: dzsp_cpu_model.sv */
`timescale 1ns/1ps
// cpu core, interrupt logic and wake source seen from the power block
module dzsp_cpu_model (
  // clock
  input wire logic pclk,
  // from the power block
  input wire logic cpu_clk_en,
  // event pulses
  output logic irq_req,
  output logic return_from_interrupt_op_op,
  output logic sleep_op,
  output logic clrwdt_op,
  output logic wake_req
);
  int cycles = 0;
  initial begin
    {irq_req, return_from_interrupt_op_op, sleep_op, clrwdt_op, wake_req} = '0;
  end
  // executed cpu cycles
  always @(posedge pclk) begin
    if (cpu_clk_en === 1'b1) cycles <= cycles + 1;
  end
  // one-cycle pulse: 0 irq, 1 return, 2 sleep, 3 wake, 4 clear watchdog
  task pulse(input int k);
    @(posedge pclk);
    case (k)
      0: irq_req <= 1'b1;
      1: return_from_interrupt_op_op <= 1'b1;
      2: sleep_op <= 1'b1;
      3: wake_req <= 1'b1;
      default: clrwdt_op <= 1'b1;
    endcase
    @(posedge pclk);
    {irq_req, return_from_interrupt_op_op, sleep_op, clrwdt_op, wake_req} <= '0;
    #1;
  endtask : pulse
endmodule : dzsp_cpu_model

/* File: dzsp_pkg.sv */
package dzsp_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] WDOG_OFS = 12'h008;
  // control register fields
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  localparam int ROI_BIT = 4;
  localparam int DOE_BIT = 5;
  localparam int IDLE_BIT = 6;
  localparam int DOZE_BIT = 7;
  // status register fields
  localparam int PD_BIT = 0;
  localparam int TO_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int IDLE_ST_BIT = 3;
  localparam int PEND_BIT = 4;
  // watchdog register fields
  localparam int WD_EN_BIT = 0;
  localparam int WD_SLP_BIT = 1;
  localparam int WD_CNT_LSB = 16;
  localparam int WD_CNT_W = 16;
  // reset values
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic ROI_RST = 1'b0;
  localparam logic DOE_RST = 1'b0;
  localparam logic IDLE_RST = 1'b0;
  localparam logic DOZE_RST = 1'b0;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam logic WD_EN_RST = 1'b0;
  localparam logic WD_SLP_RST = 1'b0;
  localparam logic [15:0] WD_LIMIT_DFLT = 16'hffff;
  // port widths
  localparam int IO_W = 8;
  localparam int OSC_N = 4;
  typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_IDLE} dzsp_pstate_t;
endpackage : dzsp_pkg

/* File: dzsp_power_ctrl.sv */
`timescale 1ns/1ps
//
// Overview of operation
// - interrupt with recover_on_interrupt 0 keeps service routine at doze rate
// - interrupt with recover_on_interrupt 1 clears doze_active, full speed at once
// - leaving doze by interrupt vectors in the very next cycle, at full speed
// - return_from_interrupt_op with doze_on_exit 1 sets doze_active
// - sleep instruction with idle_select 0 enters sleep
// - sleep entry clears watchdog counter; it runs on only if sleep-enabled
// - sleep entry clears powerdown_flag
// - sleep entry sets timeout_flag
// - cpu clock gated off while asleep
// - sleep leaves the four oscillators running
// - io ports hold their pre-sleep drive state during sleep
// - non-watchdog reset sources stay effective during sleep
module dzsp_power_ctrl import dzsp_pkg::*; #(
  parameter logic [15:0] WD_LIMIT = WD_LIMIT_DFLT
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core and interrupt logic
  input wire logic irq_req,
  input wire logic return_from_interrupt_op_op,
  input wire logic sleep_op,
  input wire logic clrwdt_op,
  input wire logic wake_req,
  output logic cpu_clk_en,
  output logic vector_go,
  // reset sources
  input wire logic mclr_pin_n,
  input wire logic bor_req,
  output logic rst_req,
  // oscillators
  input wire logic [OSC_N-1:0] osc_req,
  output logic [OSC_N-1:0] osc_en,
  // io ports
  input wire logic [IO_W-1:0] port_out_in,
  input wire logic [IO_W-1:0] port_oe_in,
  output logic [IO_W-1:0] port_out,
  output logic [IO_W-1:0] port_oe
);
  dzsp_pstate_t ps_q;
  logic [RATIO_W-1:0] ratio_q;
  logic roi_q, doe_q, idle_q, doze_q;
  logic pd_q, to_q, pend_q;
  logic wd_en_q, wd_slp_q;
  logic [WD_CNT_W-1:0] wd_cnt_q;
  logic [31:0] prdata_q;
  logic mclr_s1_q, mclr_s2_q, rst_q;
  logic [OSC_N-1:0] osc_q;
  logic [IO_W-1:0] pout_q, poe_q;
  logic doze_tick, wr_en, rd_setup, map_hit;
  logic wr_ctrl, wr_wdog;
  logic sleep_go, idle_go, wd_run, wd_hit;
  logic irq_doze_roi;

  // apb decode
  assign map_hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == WDOG_OFS);
  assign wr_en = psel && penable && pwrite && map_hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctrl = wr_en && (paddr == CTRL_OFS);
  assign wr_wdog = wr_en && (paddr == WDOG_OFS);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !map_hit;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        CTRL_OFS: begin
          prdata_q[RATIO_LSB +: RATIO_W] <= ratio_q;
          prdata_q[ROI_BIT] <= roi_q;
          prdata_q[DOE_BIT] <= doe_q;
          prdata_q[IDLE_BIT] <= idle_q;
          prdata_q[DOZE_BIT] <= doze_q;
        end
        STAT_OFS: begin
          prdata_q[PD_BIT] <= pd_q;
          prdata_q[TO_BIT] <= to_q;
          prdata_q[SLEEP_BIT] <= (ps_q == PS_SLEEP);
          prdata_q[IDLE_ST_BIT] <= (ps_q == PS_IDLE);
          prdata_q[PEND_BIT] <= pend_q;
        end
        WDOG_OFS: begin
          prdata_q[WD_EN_BIT] <= wd_en_q;
          prdata_q[WD_SLP_BIT] <= wd_slp_q;
          prdata_q[WD_CNT_LSB +: WD_CNT_W] <= wd_cnt_q;
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // control fields other than doze_active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_q <= RATIO_RST;
      roi_q <= ROI_RST;
      doe_q <= DOE_RST;
      idle_q <= IDLE_RST;
    end else if (wr_ctrl) begin
      ratio_q <= pwdata[RATIO_LSB +: RATIO_W];
      roi_q <= pwdata[ROI_BIT];
      doe_q <= pwdata[DOE_BIT];
      idle_q <= pwdata[IDLE_BIT];
    end
  end

  // doze_active: hardware events win over a software write
  assign irq_doze_roi = irq_req && doze_q && roi_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doze_q <= DOZE_RST;
    end else if (irq_doze_roi) begin
      doze_q <= 1'b0;
    end else if (return_from_interrupt_op_op && doe_q) begin
      doze_q <= 1'b1;
    end else if (wr_ctrl) begin
      doze_q <= pwdata[DOZE_BIT];
    end
  end

  // doze rate divider
  dzsp_rate_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(doze_q),
    .sel(ratio_q),
    .tick(doze_tick)
  );

  // cpu clock gate; peripherals never see this gate
  always_comb begin
    if (ps_q != PS_RUN) begin
      cpu_clk_en = 1'b0;
    end else if (doze_q) begin
      cpu_clk_en = doze_tick;
    end else begin
      cpu_clk_en = 1'b1;
    end
  end

  // pending interrupt vectors in the next enabled cpu cycle
  assign vector_go = pend_q && cpu_clk_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (irq_req) begin
      pend_q <= 1'b1;
    end else if (vector_go) begin
      pend_q <= 1'b0;
    end
  end

  // power state
  assign sleep_go = (ps_q == PS_RUN) && sleep_op && !idle_q;
  assign idle_go = (ps_q == PS_RUN) && sleep_op && idle_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= PS_RUN;
    end else begin
      unique case (ps_q)
        PS_RUN: begin
          if (sleep_go) begin
            ps_q <= PS_SLEEP;
          end else if (idle_go) begin
            ps_q <= PS_IDLE;
          end
        end
        PS_SLEEP, PS_IDLE: begin
          if (wake_req || irq_req || (wd_hit && ps_q == PS_SLEEP)) begin
            ps_q <= PS_RUN;
          end
        end
        default: begin
          ps_q <= PS_RUN;
        end
      endcase
    end
  end

  // status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_q <= PD_RST;
      to_q <= TO_RST;
    end else if (sleep_go) begin
      pd_q <= 1'b0;
      to_q <= 1'b1;
    end else if (clrwdt_op) begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end else if (wd_hit) begin
      to_q <= 1'b0;
    end
  end

  // watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_en_q <= WD_EN_RST;
      wd_slp_q <= WD_SLP_RST;
    end else if (wr_wdog) begin
      wd_en_q <= pwdata[WD_EN_BIT];
      wd_slp_q <= pwdata[WD_SLP_BIT];
    end
  end

  assign wd_run = wd_en_q && ((ps_q != PS_SLEEP) || wd_slp_q);
  assign wd_hit = wd_run && (wd_cnt_q == WD_LIMIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q <= 16'h0000;
    end else if (sleep_go || clrwdt_op || wd_hit) begin
      wd_cnt_q <= 16'h0000;
    end else if (wd_run) begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  // reset pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclr_s1_q <= 1'b1;
      mclr_s2_q <= 1'b1;
    end else begin
      mclr_s1_q <= mclr_pin_n;
      mclr_s2_q <= mclr_s1_q;
    end
  end

  // watchdog in sleep wakes instead of resetting; others always reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= !mclr_s2_q || bor_req || (wd_hit && ps_q != PS_SLEEP);
    end
  end
  assign rst_req = rst_q;

  // oscillators follow their requests regardless of power state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_req;
    end
  end
  assign osc_en = osc_q;

  // io drive latches frozen while asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pout_q <= '0;
      poe_q <= '0;
    end else if (ps_q != PS_SLEEP) begin
      pout_q <= port_out_in;
      poe_q <= port_oe_in;
    end
  end
  assign port_out = pout_q;
  assign port_oe = poe_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_roi0_keep;
    irq_req && doze_q && !roi_q && !wr_ctrl |=> doze_q;
  endproperty
  a_roi0_keep: assert property (p_roi0_keep)
    else $error("doze left on interrupt with recover off");

  property p_roi1_exit;
    irq_req && doze_q && roi_q && ps_q == PS_RUN && !sleep_op |=> !doze_q && cpu_clk_en;
  endproperty
  a_roi1_exit: assert property (p_roi1_exit)
    else $error("doze not left at full speed on interrupt");

  property p_vector_after;
    irq_req && doze_q && roi_q && ps_q == PS_RUN && !sleep_op
      |=> vector_go ##1 (!vector_go || $past(irq_req));
  endproperty
  a_vector_after: assert property (p_vector_after)
    else $error("vectoring not one cycle after interrupt");

  property p_doe_set;
    return_from_interrupt_op_op && doe_q && !irq_doze_roi |=> doze_q;
  endproperty
  a_doe_set: assert property (p_doe_set)
    else $error("doze not resumed on return");

  property p_sleep_entry;
    ps_q == PS_RUN && sleep_op && !idle_q |=> ps_q == PS_SLEEP && !cpu_clk_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered");

  property p_wdt_clear;
    sleep_go |=> wd_cnt_q == 16'h0000;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog not cleared at sleep");

  property p_flags;
    sleep_go |=> !pd_q && to_q;
  endproperty
  a_flags: assert property (p_flags)
    else $error("status flags wrong after sleep");

  property p_gate;
    ps_q == PS_SLEEP |-> !cpu_clk_en && !vector_go;
  endproperty
  a_gate: assert property (p_gate)
    else $error("cpu clock running in sleep");

  property p_osc;
    ps_q == PS_SLEEP |=> osc_en == $past(osc_req);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator enable disturbed by sleep");

  property p_hold;
    ps_q == PS_SLEEP ##1 ps_q == PS_SLEEP |-> $stable(port_out) && $stable(port_oe);
  endproperty
  a_hold: assert property (p_hold)
    else $error("io state changed in sleep");

  property p_rst;
    bor_req |=> rst_req;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset source ignored");

  property p_rate;
    cpu_clk_en && doze_q && ps_q == PS_RUN && !wr_ctrl && !irq_req
      ##1 doze_q && ps_q == PS_RUN |-> !cpu_clk_en;
  endproperty
  a_rate: assert property (p_rate)
    else $error("doze ran back-to-back cpu cycles");

  c_doze_irq: cover property (irq_req && doze_q && roi_q ##1 vector_go);
  c_sleep: cover property (sleep_go ##[1:20] ps_q == PS_RUN);
  c_doe: cover property (return_from_interrupt_op_op && doe_q ##1 doze_q ##[1:300] cpu_clk_en);
endmodule : dzsp_power_ctrl

/* File: dzsp_power_ctrl_tb.sv */
`timescale 1ns/1ps
module dzsp_power_ctrl_tb import dzsp_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic irq_req, return_from_interrupt_op_op, sleep_op, clrwdt_op, wake_req, cpu_clk_en, vector_go;
  logic bor_req, rst_req, err, mclr_n;
  logic [OSC_N-1:0] osc_req, osc_en;
  logic [IO_W-1:0] pin, poe, port_out, port_oe;
  int num_errors = 0;
  int num_checks = 0;
  int c0;
  dzsp_power_ctrl #(.WD_LIMIT(16'h0020)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .return_from_interrupt_op_op(return_from_interrupt_op_op),
    .sleep_op(sleep_op), .clrwdt_op(clrwdt_op), .wake_req(wake_req),
    .cpu_clk_en(cpu_clk_en), .vector_go(vector_go), .mclr_pin_n(mclr_n), .bor_req(bor_req),
    .rst_req(rst_req), .osc_req(osc_req), .osc_en(osc_en), .port_out_in(pin),
    .port_oe_in(poe), .port_out(port_out), .port_oe(port_oe));
  dzsp_cpu_model cpu (.pclk(pclk), .cpu_clk_en(cpu_clk_en), .irq_req(irq_req),
    .return_from_interrupt_op_op(return_from_interrupt_op_op), .sleep_op(sleep_op), .clrwdt_op(clrwdt_op), .wake_req(wake_req));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #50us;
    num_errors++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, bor_req} = '0;
    mclr_n = 1'b1;
    paddr = '0;
    pwdata = '0;
    osc_req = 4'hf;
    pin = 8'h5a;
    poe = 8'hf0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CTRL_OFS, 0);
    chk("ctrl rst", rd, 32'h0000_0000);
    apb(0, STAT_OFS, 0);
    chk("stat rst", rd, 32'h0000_0003);
    apb(0, 12'h00c, 0);
    chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
    $display("test reset done");
    apb(1, CTRL_OFS, 32'h0000_0081);
    repeat (2) @(posedge pclk);
    c0 = cpu.cycles;
    repeat (32) @(posedge pclk);
    chk("doze cycles", cpu.cycles - c0, 8);
    cpu.pulse(0);
    apb(0, CTRL_OFS, 0);
    chk("doze kept", rd, 32'h0000_0081);
    apb(1, CTRL_OFS, 32'h0000_0091);
    cpu.pulse(0);
    chk("vector", {cpu_clk_en, vector_go}, 3);
    apb(0, CTRL_OFS, 0);
    chk("doze cleared", rd, 32'h0000_0011);
    apb(1, CTRL_OFS, 32'h0000_0031);
    cpu.pulse(1);
    apb(0, CTRL_OFS, 0);
    chk("doze on exit", rd, 32'h0000_00b1);
    $display("test doze done");
    apb(1, CTRL_OFS, 0);
    apb(1, WDOG_OFS, 1);
    cpu.pulse(2);
    chk("cpu gated", cpu_clk_en, 0);
    @(posedge pclk);
    pin <= 8'ha5;
    poe <= 8'h0f;
    osc_req <= 4'h5;
    apb(0, STAT_OFS, 0);
    chk("sleep flags", rd[2:0], 3'h6);
    apb(0, WDOG_OFS, 0);
    chk("wdog clr", rd, 32'h0000_0001);
    chk("ports held", {port_out, port_oe}, 16'h5af0);
    chk("osc run", osc_en, 4'h5);
    bor_req <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("reset req", rst_req, 1);
    @(posedge pclk);
    bor_req <= 1'b0;
    mclr_n <= 1'b0;
    @(posedge pclk);
    #1;
    chk("reset off", rst_req, 0);
    repeat (2) @(posedge pclk);
    #1;
    chk("pin reset", rst_req, 1);
    @(posedge pclk);
    mclr_n <= 1'b1;
    apb(1, WDOG_OFS, 0);
    cpu.pulse(3);
    chk("woken", cpu_clk_en, 1);
    repeat (2) @(posedge pclk);
    #1;
    chk("ports free", {port_out, port_oe}, 16'ha50f);
    $display("test sleep done");
    cpu.pulse(4);
    apb(0, STAT_OFS, 0);
    chk("flags back", rd, 32'h0000_0003);
    apb(1, CTRL_OFS, 32'h0000_0040);
    cpu.pulse(2);
    chk("idle gated", cpu_clk_en, 0);
    apb(0, STAT_OFS, 0);
    chk("idle not sleep", rd, 32'h0000_000b);
    cpu.pulse(0);
    chk("idle left", {cpu_clk_en, vector_go}, 3);
    apb(1, CTRL_OFS, 0);
    $display("test idle done");
    test_done();
  end
endmodule : dzsp_power_ctrl_tb

/* File: dzsp_rate_div.sv */
`timescale 1ns/1ps
// one-cycle tick every (2 << sel) clocks while enabled
module dzsp_rate_div import dzsp_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic en,
  input wire logic [RATIO_W-1:0] sel,
  // output
  output logic tick
);
  logic [7:0] cnt_q;
  logic [8:0] ratio;

  assign ratio = 9'h002 << sel;
  // idle counter sits at zero so the first doze cycle ticks at once
  assign tick = en && (cnt_q == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (!en) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'h00) begin
      cnt_q <= 8'(ratio - 9'h001);
    end else begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : dzsp_rate_div
